// [src/phy_led_driver.sv]
// two status LED pins of the PHY: wiring sense at reset, function select, stretch
// assumes led_control_reg is written through the PHY management port and that
// the status inputs come from PHY logic on sys_clk
//
// Functional notes
// - sense each LED pin's drive polarity at reset
// - then drive each LED per led_control_reg
// - polarity latched until the next reset
// - second LED sourcing: full duplex default cleared
// - second LED sinking: full duplex default set
// - no second LED: duplex default may be either
// - functions in bits 11-8 and 7-4
// - codes on, off, blink fast, blink slow
// - tx, rx, collision, tx-or-rx activity, stretchable
// - link and duplex status steady display
// - combined codes 1100-1110 always stretched
// - stretch length in bits 3-2, 11 reserved
// - stretch about 40, 70, 140 ms
// - stretch enable bit 1 lengthens events
// - enable clear: lit only during activity
// - register reached only via management port
`timescale 1ns/1ps
`default_nettype none

module phy_led_driver
  import phy_led_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire phy_status_t phy_status,
  input wire logic reg_wr_en,
  input wire logic [15:0] reg_wr_data,
  output logic [15:0] reg_rd_data,
  input wire logic first_led_pin_in,
  output logic first_led_pin_out,
  output logic first_led_pin_oe,
  input wire logic second_led_pin_in,
  output logic second_led_pin_out,
  output logic second_led_pin_oe,
  output logic phy_full_duplex_default
);

  // stretch length for a select value; reserved value falls back to normal
  function automatic logic [7:0] stretch_ms(input logic [1:0] sel);
    case (sel)
      SEL_MEDIUM: stretch_ms = MEDIUM_STRETCH_TIME;
      SEL_LONG: stretch_ms = LONG_STRETCH_TIME;
      default: stretch_ms = NORMAL_STRETCH_TIME;
    endcase
  endfunction

  // activity event feeding the stretcher for a function code
  function automatic logic func_event(input logic [3:0] code, input phy_status_t st);
    case (code)
      FN_TX: func_event = st.tx_active;
      FN_RX, FN_LINK_RX: func_event = st.rx_active;
      FN_COL, FN_DUPLEX_COL: func_event = st.col_active;
      FN_TXRX, FN_LINK_TXRX: func_event = st.tx_active | st.rx_active;
      default: func_event = 1'b0;
    endcase
  endfunction

  // codes whose activity obeys the stretch enable
  function automatic logic func_stretchable(input logic [3:0] code);
    func_stretchable = (code == FN_TX) || (code == FN_RX) || (code == FN_COL)
      || (code == FN_TXRX);
  endfunction

  // codes that are stretched whatever the enable says
  function automatic logic func_always(input logic [3:0] code);
    func_always = (code == FN_LINK_RX) || (code == FN_LINK_TXRX)
      || (code == FN_DUPLEX_COL);
  endfunction

  // lit state of an LED for its code; combined codes toggle the steady status on activity
  function automatic logic func_lit(input logic [3:0] code, input phy_status_t st,
                                    input logic act, input logic fast, input logic slow);
    case (code)
      FN_ON: func_lit = 1'b1;
      FN_OFF: func_lit = 1'b0;
      FN_BLINK_FAST: func_lit = fast;
      FN_BLINK_SLOW: func_lit = slow;
      FN_TX, FN_RX, FN_COL, FN_TXRX: func_lit = act;
      FN_LINK: func_lit = st.link_up;
      FN_DUPLEX: func_lit = st.full_duplex;
      FN_LINK_RX, FN_LINK_TXRX: func_lit = st.link_up ^ act;
      FN_DUPLEX_COL: func_lit = st.full_duplex ^ act;
      default: func_lit = 1'b0;
    endcase
  endfunction

  led_cfg_t cfg_reg, cfg_next;
  logic [1:0] sync1_reg, sync2_reg, sync3_reg, stable_reg, stable_next;
  sense_state_t state_reg, state_next;
  logic [4:0] sense_cnt_reg, sense_cnt_next;
  logic [1:0] pol_reg, pol_next;
  logic dpx_reg, dpx_next;
  logic [15:0] tick_cnt_reg, tick_cnt_next;
  logic ms_tick;
  logic [7:0] fast_cnt_reg, fast_cnt_next, slow_cnt_reg, slow_cnt_next;
  logic fast_ph_reg, fast_ph_next, slow_ph_reg, slow_ph_next;
  logic [7:0] str_cnt_reg [2];
  logic [7:0] str_cnt_next [2];
  logic [3:0] code [2];
  logic [1:0] evt, stretch_on, act, lit;
  logic [1:0] led_out_reg, led_out_next, led_oe_reg, led_oe_next;

  assign code[0] = cfg_reg.first_led_function;
  assign code[1] = cfg_reg.second_led_function;

  // led_control_reg: written and read back only over the management port
  always_comb begin
    cfg_next = cfg_reg;
    if (reg_wr_en) begin
      cfg_next = led_cfg_t'(reg_wr_data);
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cfg_reg <= led_cfg_t'(LED_CFG_RESET);
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign reg_rd_data = cfg_reg;

  // pin level filter: accept a change once the second and third stages agree
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      stable_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : stable_reg[i];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
      sync3_reg <= 2'h0;
      stable_reg <= 2'h0;
    end else begin
      sync1_reg <= {second_led_pin_in, first_led_pin_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      stable_reg <= stable_next;
    end
  end

  // wiring sense: a pin that floats high has its LED tied to supply (sinking, lit low)
  always_comb begin
    state_next = state_reg;
    sense_cnt_next = sense_cnt_reg;
    pol_next = pol_reg;
    dpx_next = dpx_reg;
    case (state_reg)
      ST_SENSE: begin
        if (sense_cnt_reg == SENSE_CYCLES - 5'h1) begin
          pol_next = stable_reg;
          dpx_next = stable_reg[1];
          state_next = ST_RUN;
        end else begin
          sense_cnt_next = sense_cnt_reg + 5'h1;
        end
      end
      ST_RUN: begin
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_SENSE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_SENSE;
      sense_cnt_reg <= 5'h0;
      pol_reg <= 2'h0;
      dpx_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sense_cnt_reg <= sense_cnt_next;
      pol_reg <= pol_next;
      dpx_reg <= dpx_next;
    end
  end

  assign phy_full_duplex_default = dpx_reg;

  // millisecond tick and the two blink phases
  assign ms_tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));

  always_comb begin
    tick_cnt_next = ms_tick ? 16'h0 : tick_cnt_reg + 16'h1;
    fast_cnt_next = fast_cnt_reg;
    slow_cnt_next = slow_cnt_reg;
    fast_ph_next = fast_ph_reg;
    slow_ph_next = slow_ph_reg;
    if (ms_tick) begin
      if (fast_cnt_reg == FAST_BLINK_HALF_MS - 8'h1) begin
        fast_cnt_next = 8'h0;
        fast_ph_next = ~fast_ph_reg;
      end else begin
        fast_cnt_next = fast_cnt_reg + 8'h1;
      end
      if (slow_cnt_reg == SLOW_BLINK_HALF_MS - 8'h1) begin
        slow_cnt_next = 8'h0;
        slow_ph_next = ~slow_ph_reg;
      end else begin
        slow_cnt_next = slow_cnt_reg + 8'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tick_cnt_reg <= 16'h0;
      fast_cnt_reg <= 8'h0;
      slow_cnt_reg <= 8'h0;
      fast_ph_reg <= 1'b0;
      slow_ph_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      fast_cnt_reg <= fast_cnt_next;
      slow_cnt_reg <= slow_cnt_next;
      fast_ph_reg <= fast_ph_next;
      slow_ph_reg <= slow_ph_next;
    end
  end

  // per-LED stretcher: an event reloads the count, ms ticks run it down
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      evt[i] = func_event(code[i], phy_status);
      stretch_on[i] = func_always(code[i])
        || (func_stretchable(code[i]) && cfg_reg.stretch_enable);
      str_cnt_next[i] = str_cnt_reg[i];
      if (evt[i] && stretch_on[i]) begin
        str_cnt_next[i] = stretch_ms(cfg_reg.stretch_length_select);
      end else if (!stretch_on[i]) begin
        str_cnt_next[i] = 8'h0;
      end else if (ms_tick && (str_cnt_reg[i] != 8'h0)) begin
        str_cnt_next[i] = str_cnt_reg[i] - 8'h1;
      end
      act[i] = evt[i] || (stretch_on[i] && (str_cnt_reg[i] != 8'h0));
      lit[i] = func_lit(code[i], phy_status, act[i], fast_ph_reg, slow_ph_reg);
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      str_cnt_reg[0] <= 8'h0;
      str_cnt_reg[1] <= 8'h0;
    end else begin
      str_cnt_reg[0] <= str_cnt_next[0];
      str_cnt_reg[1] <= str_cnt_next[1];
    end
  end

  // pin drive: released while sensing, then lit level adjusted by the latched polarity
  always_comb begin
    led_out_next = 2'h0;
    led_oe_next = 2'h0;
    if (state_reg == ST_RUN) begin
      led_oe_next = 2'h3;
      led_out_next = lit ^ pol_reg;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      led_out_reg <= 2'h0;
      led_oe_reg <= 2'h0;
    end else begin
      led_out_reg <= led_out_next;
      led_oe_reg <= led_oe_next;
    end
  end

  assign first_led_pin_out = led_out_reg[0];
  assign first_led_pin_oe = led_oe_reg[0];
  assign second_led_pin_out = led_out_reg[1];
  assign second_led_pin_oe = led_oe_reg[1];

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_sense_released: assert property (
    (state_reg == ST_SENSE) |=> (led_oe_reg == 2'h0))
    else $error("led pins driven while sensing wiring");
  chk_run_driven: assert property (
    (state_reg == ST_RUN) |=> (led_oe_reg == 2'h3))
    else $error("led pins not driven after sensing");
  chk_pol_held: assert property (
    (state_reg == ST_RUN) |=> ($stable(pol_reg) && $stable(dpx_reg) && state_reg == ST_RUN))
    else $error("latched polarity changed in operation");
  chk_dpx_latch: assert property (
    (state_reg == ST_SENSE && sense_cnt_reg == SENSE_CYCLES - 5'h1)
      |=> (phy_full_duplex_default == $past(stable_reg[1]) && pol_reg == $past(stable_reg)))
    else $error("duplex default or polarity not taken from sensed wiring");
  chk_on_code: assert property (
    (state_reg == ST_RUN && code[0] == FN_ON) |=> (first_led_pin_out == !pol_reg[0]))
    else $error("first led not lit for on code");
  chk_off_code: assert property (
    (state_reg == ST_RUN && code[1] == FN_OFF) |=> (second_led_pin_out == pol_reg[1]))
    else $error("second led not dark for off code");
  chk_link_code: assert property (
    (state_reg == ST_RUN && code[0] == FN_LINK)
      |=> (first_led_pin_out == ($past(phy_status.link_up) ^ pol_reg[0])))
    else $error("first led does not follow link");
  chk_stretch_load: assert property (
    (evt[0] && stretch_on[0] && !reg_wr_en)
      |=> (str_cnt_reg[0] == stretch_ms(cfg_reg.stretch_length_select)))
    else $error("stretch count not loaded on event");
  chk_no_stretch: assert property (
    (state_reg == ST_RUN && code[1] == FN_TX && !cfg_reg.stretch_enable)
      |=> (second_led_pin_out == ($past(phy_status.tx_active) ^ pol_reg[1])))
    else $error("unstretched activity not shown directly");
  chk_reserved_dark: assert property (
    (state_reg == ST_RUN && code[0] == 4'h0) |=> (first_led_pin_out == pol_reg[0]))
    else $error("reserved code does not leave led dark");
  chk_reg_write: assert property (
    reg_wr_en |=> (reg_rd_data == $past(reg_wr_data)))
    else $error("register write not stored");

endmodule // phy_led_driver

`default_nettype wire

// [src/phy_led_pkg.sv]
// constants, field layouts and carrier types for the PHY status LED driver
// assumes a 25 MHz main clock and a PHY core on the same clock
package phy_led_pkg;

  // main clock period and the millisecond time base derived from it
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_TIME_NS = 1000000;
  localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;

  // cycles the pins stay undriven while wiring is sensed after reset
  localparam logic [4:0] SENSE_CYCLES = 5'h10;

  // stretch lengths in milliseconds (normal, medium, long)
  localparam logic [7:0] NORMAL_STRETCH_TIME = 8'h28;
  localparam logic [7:0] MEDIUM_STRETCH_TIME = 8'h46;
  localparam logic [7:0] LONG_STRETCH_TIME = 8'h8C;

  // blink half periods in milliseconds
  localparam logic [7:0] FAST_BLINK_HALF_MS = 8'h32;
  localparam logic [7:0] SLOW_BLINK_HALF_MS = 8'hFA;

  // led_control_reg value after reset
  localparam logic [15:0] LED_CFG_RESET = 16'h3420;

  // stretch length select encodings
  localparam logic [1:0] SEL_NORMAL = 2'h0;
  localparam logic [1:0] SEL_MEDIUM = 2'h1;
  localparam logic [1:0] SEL_LONG = 2'h2;

  // led function codes
  localparam logic [3:0] FN_TX = 4'h1;
  localparam logic [3:0] FN_RX = 4'h2;
  localparam logic [3:0] FN_COL = 4'h3;
  localparam logic [3:0] FN_LINK = 4'h4;
  localparam logic [3:0] FN_DUPLEX = 4'h5;
  localparam logic [3:0] FN_TXRX = 4'h7;
  localparam logic [3:0] FN_ON = 4'h8;
  localparam logic [3:0] FN_OFF = 4'h9;
  localparam logic [3:0] FN_BLINK_FAST = 4'hA;
  localparam logic [3:0] FN_BLINK_SLOW = 4'hB;
  localparam logic [3:0] FN_LINK_RX = 4'hC;
  localparam logic [3:0] FN_LINK_TXRX = 4'hD;
  localparam logic [3:0] FN_DUPLEX_COL = 4'hE;

  // led_control_reg layout, bit 15 first
  typedef struct packed {
    logic [3:0] reserved_hi;
    logic [3:0] first_led_function;
    logic [3:0] second_led_function;
    logic [1:0] stretch_length_select;
    logic stretch_enable;
    logic reserved_lo;
  } led_cfg_t;

  // indications coming from the rest of the PHY
  typedef struct packed {
    logic link_up;
    logic full_duplex;
    logic tx_active;
    logic rx_active;
    logic col_active;
  } phy_status_t;

  // wiring sense sequencer
  typedef enum logic [0:0] {ST_SENSE, ST_RUN} sense_state_t;

endpackage

// [sim/led_wiring_model.sv]
// two external LEDs on the driver's pins: resolves each pin level and reports glow
// assumes oe is high while the driver drives the pin; sink_* picks the wiring
`timescale 1ns/1ps
`default_nettype none

module led_wiring_model (
  input wire logic sink_first,
  input wire logic sink_second,
  input wire logic out_first,
  input wire logic oe_first,
  input wire logic out_second,
  input wire logic oe_second,
  output logic pin_first,
  output logic pin_second,
  output logic lit_first,
  output logic lit_second
);
  // an undriven pin is pulled by its led toward the rail that led hangs from
  assign pin_first = oe_first ? out_first : sink_first;
  assign pin_second = oe_second ? out_second : sink_second;
  // sourcing led glows on a driven high, sinking led on a driven low
  assign lit_first = oe_first & (out_first ^ sink_first);
  assign lit_second = oe_second & (out_second ^ sink_second);
endmodule // led_wiring_model

`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the PHY status LED driver
// assumes the LED wiring model beside it and a shortened millisecond tick
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import phy_led_pkg::*;
  localparam int TICK = 10;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  phy_status_t phy_status = '0;
  logic reg_wr_en = 1'b0;
  logic [15:0] reg_wr_data = 16'h0000;
  logic [15:0] reg_rd_data;
  logic pin_a, pin_b, out_a, out_b, oe_a, oe_b, lit_a, lit_b, dpx;
  logic sink_a = 1'b0;
  logic sink_b = 1'b1;
  int n_errors = 0;
  int tests_run = 0;

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;

  phy_led_driver #(.TICK_CYCLES(TICK)) u_dut (.sys_clk(sys_clk), .reset(reset),
    .phy_status(phy_status), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .first_led_pin_in(pin_a), .first_led_pin_out(out_a),
    .first_led_pin_oe(oe_a), .second_led_pin_in(pin_b), .second_led_pin_out(out_b),
    .second_led_pin_oe(oe_b), .phy_full_duplex_default(dpx));

  led_wiring_model u_leds (.sink_first(sink_a), .sink_second(sink_b), .out_first(out_a),
    .oe_first(oe_a), .out_second(out_b), .oe_second(oe_b), .pin_first(pin_a),
    .pin_second(pin_b), .lit_first(lit_a), .lit_second(lit_b));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one comparison of a result against its expected value
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // one register write; reserved bits go out as software must write them
  task automatic wr(input logic [3:0] fa, input logic [3:0] fb, input logic [1:0] sel,
                    input logic en);
    reg_wr_data = {4'h3, fa, fb, sel, en, 1'b0}; // reserved bit values
    reg_wr_en = 1'b1;
    cyc(1);
    reg_wr_en = 1'b0;
    cyc(2);
    check("readback", {4'h3, fa, fb, sel, en, 1'b0}, reg_rd_data); // field layout
  endtask

  task automatic pulse(input phy_status_t s);
    phy_status = s;
    cyc(1);
    phy_status = '0;
  endtask

  // reset with a given wiring, then wait a bounded time for both pins to be driven
  task automatic do_reset(input logic sa, input logic sb);
    int i;
    sink_a = sa;
    sink_b = sb;
    phy_status = '0;
    reset = 1'b1;
    cyc(8);
    reset = 1'b0;
    cyc(2);
    check("oe_sensing", 16'h0000, {oe_a, oe_b}); // pins left free while sensing
    for (i = 0; i < 40 && {oe_a, oe_b} !== 2'b11; i++) cyc(1);
    if (i == 40) begin
      check("oe_ready", 16'h0003, {oe_a, oe_b}); // pins driven after sensing
      report_and_stop();
    end
  endtask

  task automatic t_sense();
    do_reset(1'b0, 1'b1);
    check("duplex_default", 16'h0001, dpx); // sinking second pin
    check("cfg_reset", LED_CFG_RESET, reg_rd_data); // default indication source
    phy_status = 5'h12;
    cyc(2);
    check("lit_default", 16'h0003, {lit_a, lit_b}); // polarity per pin and default
    sink_b = 1'b0;
    cyc(8);
    check("out_held", 16'h0000, out_b); // polarity kept until reset
    check("dpx_held", 16'h0001, dpx); // duplex default kept until reset
    do_reset(1'b1, 1'b0);
    check("duplex_default", 16'h0000, dpx); // sourcing second pin
    phy_status = 5'h12;
    cyc(2);
    check("lit_swapped", 16'h0003, {lit_a, lit_b}); // new polarity after reset
    $display("test sense done");
  endtask

  task automatic t_fixed();
    wr(FN_ON, FN_OFF, SEL_NORMAL, 1'b0);
    check("on_off", 16'h0002, {lit_a, lit_b}); // on and off codes
    wr(FN_OFF, FN_ON, SEL_NORMAL, 1'b0);
    check("off_on", 16'h0001, {lit_a, lit_b}); // on and off codes
    $display("test fixed done");
  endtask

  // stretchable codes with stretching off follow the activity itself
  task automatic t_activity();
    logic [3:0] code[4] = '{FN_TX, FN_RX, FN_COL, FN_TXRX};
    logic [4:0] act[4] = '{5'h04, 5'h02, 5'h01, 5'h04};
    for (int k = 0; k < 4; k++) begin
      wr(code[k], code[k], SEL_LONG, 1'b0);
      phy_status = act[k];
      cyc(2);
      check("act_on", 16'h0003, {lit_a, lit_b}); // activity sources
      phy_status = '0;
      cyc(2);
      check("act_off", 16'h0000, {lit_a, lit_b}); // no stretch when disabled
    end
    $display("test activity done");
  endtask

  task automatic t_status();
    wr(FN_LINK, FN_DUPLEX, SEL_NORMAL, 1'b0);
    phy_status = 5'h10;
    cyc(2);
    check("link_dup", 16'h0002, {lit_a, lit_b}); // link and duplex display
    phy_status = 5'h08;
    cyc(2);
    check("link_dup", 16'h0001, {lit_a, lit_b}); // link and duplex display
    $display("test status done");
  endtask

  task automatic t_reserved();
    logic [3:0] code[3] = '{4'h0, 4'h6, 4'hF};
    phy_status = 5'h1F;
    for (int k = 0; k < 3; k++) begin
      wr(code[k], code[k], SEL_NORMAL, 1'b1);
      check("reserved", 16'h0000, {lit_a, lit_b}); // reserved codes dark
    end
    phy_status = '0;
    $display("test reserved done");
  endtask

  // one-cycle event stretched by each length select, reserved select included
  task automatic t_stretch();
    int len[4] = '{int'(NORMAL_STRETCH_TIME), int'(MEDIUM_STRETCH_TIME),
                   int'(LONG_STRETCH_TIME), int'(NORMAL_STRETCH_TIME)};
    for (int s = 0; s < 4; s++) begin
      wr(FN_TX, FN_COL, 2'(s), 1'b1);
      pulse(5'h04);
      cyc(len[s] * TICK - 2 * TICK);
      check("stretch_lit", 16'h0002, {lit_a, lit_b}); // stretch length
      cyc(3 * TICK);
      check("stretch_end", 16'h0000, {lit_a, lit_b}); // stretch length
    end
    $display("test stretch done");
  endtask

  task automatic t_combined();
    wr(FN_LINK_RX, FN_DUPLEX_COL, SEL_NORMAL, 1'b0);
    pulse(5'h03);
    cyc(20 * TICK);
    check("combo_lit", 16'h0003, {lit_a, lit_b}); // always stretched
    cyc(25 * TICK);
    check("combo_end", 16'h0000, {lit_a, lit_b}); // always stretched
    $display("test combined done");
  endtask

  task automatic t_blink();
    int fa = 0;
    int sb = 0;
    logic pa, pb;
    wr(FN_BLINK_FAST, FN_BLINK_SLOW, SEL_NORMAL, 1'b0);
    pa = lit_a;
    pb = lit_b;
    repeat (5200) begin
      cyc(1);
      fa += int'(lit_a !== pa);
      sb += int'(lit_b !== pb);
      pa = lit_a;
      pb = lit_b;
    end
    check("fast_blink", 16'h0001, 16'(fa >= 9 && fa <= 11)); // fast blink rate
    check("slow_blink", 16'h0001, 16'(sb >= 1 && sb <= 3)); // slow blink rate
    $display("test blink done");
  endtask

  // main sequence
  initial begin
    t_sense();
    t_fixed();
    t_activity();
    t_status();
    t_reserved();
    t_stretch();
    t_combined();
    t_blink();
    report_and_stop();
  end
endmodule // tb_top

`default_nettype wire
